// file: rtl/efpc_top.v
// Register file, seed reload and power-down control of the fractional-N synthesizer
// Notes on behaviour
// - Channel mode: only fractional word rewritten
// - Seed sets accumulator start phase, exact mode
// - New fractional word reloads seed in exact mode
// - Power-on reset holds defaults for 250us
// - Write to register zero soft-resets
// - Pin control set: enable pin low powers down
// - Pin control clear: software bit decides
// - Register port works during power down
// - Fractional word is value over 2^24
// - Integer divider holds ratio, minimum 20
`timescale 1ns/1ps
`default_nettype none
`include "efpc_regs.vh"
module efpc_top (
    input wire mclk,
    input wire nrst,
    input wire wr_en,
    input wire [`EFPC_AW-1:0] wr_addr,
    input wire [`EFPC_DW-1:0] wr_data,
    input wire rd_en,
    output reg [`EFPC_DW-1:0] rd_data,
    input wire power_enable_pin,
    output reg power_down,
    output reg por_busy,
    output reg [`EFPC_DW-1:0] int_ratio,
    output reg [`EFPC_DW-1:0] frac_word,
    output reg [`EFPC_DW-1:0] exact_div,
    output reg exact_mode,
    output reg [`EFPC_DW-1:0] digital_phase_accumulator,
    output reg seed_load
);
    // ==========================================================
    // Power-on timing
    // Rounded up so the hold is never shorter than the stated time
    localparam [31:0] POR_CYC = (`EFPC_POR_NS + `EFPC_CLK_NS - 1) / `EFPC_CLK_NS;
    localparam [`EFPC_POR_W-1:0] POR_LAST = POR_CYC[`EFPC_POR_W-1:0]
        - {{(`EFPC_POR_W-1){1'b0}}, 1'b1};
    reg [`EFPC_POR_W-1:0] por_cnt;
    reg [`EFPC_DW-1:0] id_reg;
    reg [`EFPC_DW-1:0] pwr_reg;
    reg [`EFPC_DW-1:0] seed_reg;
    wire pin_sync;
    reg [`EFPC_DW-1:0] next_rd_data;
    reg next_power_down;
    wire do_wr;
    wire soft_rst;

    efpc_sync2 u_pin_sync (
        .mclk(mclk),
        .nrst(nrst),
        .din(power_enable_pin),
        .dout(pin_sync)
    );

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            por_cnt <= {`EFPC_POR_W{1'b0}};
            por_busy <= 1'b1;
        end else if (por_busy) begin
            if (por_cnt == POR_LAST)
                por_busy <= 1'b0;
            else
                por_cnt <= por_cnt + 1'b1;
        end
    end

    // ==========================================================
    // Write decode
    wire load_dflt;
    wire wr_pwr;
    wire wr_int;
    wire wr_frac;
    wire wr_exact;
    wire wr_seed;
    wire int_low;
    // Writes during the power-on hold are dropped so defaults settle first
    assign do_wr = wr_en && !por_busy;
    assign soft_rst = do_wr && (wr_addr == `EFPC_REG_ID);
    assign load_dflt = por_busy || soft_rst;
    // Unmapped addresses decode to no strobe and are dropped silently
    assign wr_pwr = do_wr && (wr_addr == `EFPC_REG_PWR);
    assign wr_int = do_wr && (wr_addr == `EFPC_REG_INT);
    assign wr_frac = do_wr && (wr_addr == `EFPC_REG_FRAC);
    assign wr_exact = do_wr && (wr_addr == `EFPC_REG_EXACT);
    assign wr_seed = do_wr && (wr_addr == `EFPC_REG_SEED);
    assign int_low = (wr_data < `EFPC_INT_MIN);

    // ==========================================================
    // Register file, one process per register
    // read pointer kept
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            id_reg <= `EFPC_RST_ID;
        end else if (por_busy) begin
            id_reg <= `EFPC_RST_ID;
        end else if (soft_rst) begin
            id_reg <= {{(`EFPC_DW-`EFPC_RPTR_MSB-1){1'b0}}, wr_data[`EFPC_RPTR_MSB:0]};
        end
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pwr_reg <= `EFPC_RST_PWR;
        end else if (load_dflt) begin
            pwr_reg <= `EFPC_RST_PWR;
        end else if (wr_pwr) begin
            pwr_reg <= wr_data;
        end
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            int_ratio <= `EFPC_RST_INT;
        end else if (load_dflt) begin
            int_ratio <= `EFPC_RST_INT;
        end else if (wr_int) begin
            if (int_low)
                int_ratio <= `EFPC_INT_MIN;
            else
                int_ratio <= wr_data;
        end
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            frac_word <= `EFPC_RST_FRAC;
        end else if (load_dflt) begin
            frac_word <= `EFPC_RST_FRAC;
        end else if (wr_frac) begin
            frac_word <= wr_data;
        end
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            exact_div <= `EFPC_RST_EXACT;
        end else if (load_dflt) begin
            exact_div <= `EFPC_RST_EXACT;
        end else if (wr_exact) begin
            exact_div <= wr_data;
        end
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            seed_reg <= `EFPC_RST_SEED;
        end else if (load_dflt) begin
            seed_reg <= `EFPC_RST_SEED;
        end else if (wr_seed) begin
            seed_reg <= wr_data;
        end
    end

    // ==========================================================
    // Seed reload into the phase accumulator
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            exact_mode <= 1'b0;
            seed_load <= 1'b0;
            digital_phase_accumulator <= `EFPC_RST_SEED;
        end else begin
            exact_mode <= (exact_div != `EFPC_RST_EXACT);
            seed_load <= wr_frac && (exact_div != `EFPC_RST_EXACT);
            // Reload a cycle after the write so a seed written just before is used
            if (seed_load)
                digital_phase_accumulator <= seed_reg;
            else if (load_dflt)
                digital_phase_accumulator <= `EFPC_RST_SEED;
        end
    end

    // ==========================================================
    // Power down and readback
    always @* begin
        if (pwr_reg[`EFPC_PWR_PIN_BIT])
            next_power_down = !pin_sync;
        else
            next_power_down = pwr_reg[`EFPC_PWR_SW_BIT];
        // Readback follows the pointer in register zero, not the write address
        // Nothing here is gated by power down, so the host can always read back
        case (id_reg[`EFPC_RPTR_MSB:0])
            `EFPC_REG_ID: next_rd_data = id_reg;
            `EFPC_REG_PWR: next_rd_data = pwr_reg;
            `EFPC_REG_INT: next_rd_data = int_ratio;
            `EFPC_REG_FRAC: next_rd_data = frac_word;
            `EFPC_REG_EXACT: next_rd_data = exact_div;
            `EFPC_REG_SEED: next_rd_data = seed_reg;
            default: next_rd_data = {`EFPC_DW{1'b0}};
        endcase
    end

    // port never gated by power down
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            power_down <= 1'b0;
            rd_data <= {`EFPC_DW{1'b0}};
        end else begin
            power_down <= next_power_down;
            if (rd_en)
                rd_data <= next_rd_data;
        end
    end
endmodule // efpc_top
`default_nettype wire

// file: pkg/efpc_regs.vh
// Register map, field positions, reset values and timing for the synthesizer control block
`ifndef EFPC_REGS_VH
`define EFPC_REGS_VH
`define EFPC_AW 5
`define EFPC_DW 24
`define EFPC_REG_ID 5'h00
`define EFPC_REG_PWR 5'h01
`define EFPC_REG_INT 5'h03
`define EFPC_REG_FRAC 5'h04
`define EFPC_REG_EXACT 5'h0C
`define EFPC_REG_SEED 5'h1A
`define EFPC_PWR_PIN_BIT 0
`define EFPC_PWR_SW_BIT 1
`define EFPC_RPTR_MSB 4
`define EFPC_RST_ID 24'h000000
`define EFPC_RST_PWR 24'h000001
`define EFPC_RST_INT 24'h000014
`define EFPC_RST_FRAC 24'h000000
`define EFPC_RST_EXACT 24'h000000
`define EFPC_RST_SEED 24'h000000
`define EFPC_INT_MIN 24'h000014
`define EFPC_POR_NS 250000
`define EFPC_CLK_NS 100
`define EFPC_POR_W 12
`endif

// file: rtl/efpc_sync2.v
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module efpc_sync2 (
    input wire mclk,
    input wire nrst,
    input wire din,
    output reg dout
);
    reg stage1;
    always @(posedge mclk or negedge nrst) begin
        // Resets to the run level of the enable pin, so power down does not pulse after reset
        if (!nrst) begin
            stage1 <= 1'b1;
            dout <= 1'b1;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule // efpc_sync2
`default_nettype wire

// file: testbench/efpc_sva.sv
// Port assertions for the synthesizer control block
`timescale 1ns/1ps
`default_nettype none
module efpc_sva (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [23:0] wr_data,
    input wire logic power_down,
    input wire logic por_busy,
    input wire logic [23:0] int_ratio,
    input wire logic [23:0] frac_word,
    input wire logic [23:0] exact_div,
    input wire logic seed_load
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire ok = wr_en && !por_busy;
    wire fw = ok && wr_addr == 5'h04;
    wire fx = fw && exact_div != 24'h000000;
    // A second fraction write in the next cycle legally stretches the pulse
    sequence s_pulse; seed_load ##1 (!seed_load || $past(fx)); endsequence
    a_seed_pulse: assert property (fx |=> s_pulse) else $error("no reload");
    a_seed_cause: assert property (seed_load |-> $past(fx)) else $error("stray");
    a_no_exact: assert property (fw && !fx |=> !seed_load) else $error("reload");
    a_frac_take: assert property (fw |=> frac_word == $past(wr_data)) else $error("frac");
    a_int_floor: assert property (ok && wr_addr == 5'h03 |=> int_ratio ==
        ($past(wr_data) < 24'h000014 ? 24'h000014 : $past(wr_data))) else $error("int");
    a_soft_reset: assert property (ok && wr_addr == 5'h00 |=> int_ratio == 24'h000014
        && exact_div == 24'h000000) else $error("soft");
    a_sw_power: assert property (ok && wr_addr == 5'h01 && !wr_data[0] |-> ##2
        power_down == $past(wr_data[1], 2)) else $error("power");
    a_por_hold: assert property (por_busy |=> $stable(frac_word)) else $error("por");
endmodule // efpc_sva
bind efpc_top efpc_sva u_sva (.mclk(mclk), .nrst(nrst), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .power_down(power_down), .por_busy(por_busy), .int_ratio(int_ratio),
    .frac_word(frac_word), .exact_div(exact_div), .seed_load(seed_load));
`default_nettype wire

// file: testbench/efpc_host.sv
// Host model programming the control block registers
`timescale 1ns/1ps
`default_nettype none
module efpc_host (
    input wire logic mclk,
    output logic wr_en,
    output logic [4:0] wr_addr,
    output logic [23:0] wr_data,
    output logic rd_en
);
    initial {wr_en, wr_addr, wr_data, rd_en} = 31'h0;
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(posedge mclk) #1 {wr_en, wr_addr, wr_data} = {1'b1, a, d};
        @(posedge mclk) #1 wr_en = 1'b0;
    endtask
    // Pointer write soft-resets too, so only defaults read back
    task automatic rd(input logic [4:0] a);
        wr(5'h00, {19'h0, a});
        @(posedge mclk) #1 rd_en = 1'b1;
        @(posedge mclk) #1 rd_en = 1'b0;
    endtask
    // Base, step divisor, odd seed; channels share one interval
    task automatic plan();
        wr(5'h03, 24'h00002D);
        wr(5'h0C, 24'h000C00);
        wr(5'h1A, 24'h5A3C71);
    endtask
endmodule // efpc_host
`default_nettype wire

// file: testbench/efpc_top_tb_top.sv
// Self-checking testbench for the synthesizer control block
`timescale 1ns/1ps
`default_nettype none
module efpc_top_tb_top;
    logic mclk = 1'b0;
    logic nrst, pin, wr_en, rd_en, pd, busy, sl, em;
    logic [4:0] wr_addr;
    logic [23:0] wr_data, rd_data, iq, fq, ed, acc;
    int n_fail = 0;
    int n_checks = 0;
    efpc_host h (.mclk(mclk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en));
    efpc_top DUT (.mclk(mclk), .nrst(nrst), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .power_enable_pin(pin),
        .power_down(pd), .por_busy(busy), .int_ratio(iq), .frac_word(fq), .exact_div(ed),
        .exact_mode(em), .digital_phase_accumulator(acc), .seed_load(sl));
    initial forever #50 mclk = ~mclk;
    task automatic chk(input logic [23:0] s, input logic [23:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_por();
        h.wr(5'h04, 24'h000123);
        chk(fq, 24'h000000);
        for (int i = 0; i < 3000 && busy; i++) #100;
        chk({23'h0, busy}, 24'h000000);
        chk(iq, 24'h000014);
    endtask
    // Channel step rewrites only the fraction
    task automatic t_chan(input logic [23:0] f);
        h.wr(5'h04, f);
        chk(fq, f);
        chk({23'h0, sl}, 24'h000001);
        chk({23'h0, em}, 24'h000001);
        #100 chk(acc, 24'h5A3C71);
    endtask
    task automatic t_soft();
        h.wr(5'h00, 24'h000000);
        chk(ed, 24'h000000);
        chk(acc, 24'h000000);
        h.wr(5'h04, 24'h000777);
        chk({23'h0, sl}, 24'h000000);
        chk({23'h0, em}, 24'h000000);
        h.wr(5'h03, 24'h000005);
        chk(iq, 24'h000014);
    endtask
    task automatic t_pwr();
        pin = 1'b0;
        #400 chk({23'h0, pd}, 24'h000001);
        h.rd(5'h01);
        chk(rd_data, 24'h000001);
        h.rd(5'h1F);
        chk(rd_data, 24'h000000);
        h.wr(5'h01, 24'h000000);
        #100 chk({23'h0, pd}, 24'h000000);
        h.wr(5'h01, 24'h000002);
        #100 chk({23'h0, pd}, 24'h000001);
    endtask
    initial begin
        {nrst, pin} = 2'b01;
        repeat (3) @(posedge mclk);
        #1 nrst = 1'b1;
        t_por();
        // A hold that never ends has already counted a mismatch
        if (!busy) begin
            h.plan();
            t_chan(24'h938000);
            t_chan(24'h93EAAB);
            t_soft();
            t_pwr();
        end
        complete_run();
    end
endmodule // efpc_top_tb_top
`default_nettype wire
